// [dtm_top.sv]
// Dual timer top: Avalon-MM register file, RTC seconds counter, interrupts
//
// Notes on behaviour
// [R01] Enable bits start half A, half B, or both in one write.
// [R02] Software configures a half before enabling it.
// [R03] Writing ones to the clear register drops exactly those sources.
// [R04] Software should clear sources early; clearing takes a bus cycle.
// [R05] Interrupt line is OR of pending sources that are enabled.
// [R06] Seven sources: event, match, timeout per half, plus RTC match.
// [R07] Raw and masked status both readable with the enable bit layout.
// [R08] Joined 32-bit mode uses half A registers only; half B idles.
// [R09] Load value reads back as written, untouched by counting.
// [R10] Load write while running reloads the live counter at once.
// [R11] Edge-count capture raises match when the count, stepped down from load per edge, reaches match.
// [R12] Pulse output duty is set by match against the load period.
// [R13] Prescaler per half takes 0 to 255, settable on A, B or both.
// [R14] Prescaler divides only in split 16-bit modes.
// [R15] Prescale value reads back without change.
// [R16] One-shot stops at zero; periodic reloads and keeps counting.
// [R17] RTC mode counts seconds from the 32 KHz input, divided down.
// [R18] Capture modes count edges or time them; edge rise, fall or both.
// [R19] Raw status bits stick until cleared, whatever their enables.
// [R20] Split counters count down per prescaled tick, timeout at zero.
`timescale 1ns/1ns
module dtm_top
  import dtm_pkg::*;
#(
  parameter int RTC_DIV = DTM_RTC_DIV
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Capture and pulse pins
  input wire logic cap_a_in,
  input wire logic cap_b_in,
  output logic pwm_a_out,
  output logic pwm_b_out,
  // 32 KHz reference, synchronous to mclk
  input wire logic rtc_ref_in,
  // Processor interrupt
  output logic irq
);

  // ==========================================================
  // Elaboration checks
  if (RTC_DIV < 2 || RTC_DIV > 65536) begin : g_bad_div
    $error("RTC_DIV must lie in 2 to 65536");
  end

  // Map a mode field, unknown codes fall back to one-shot
  function automatic dtm_mode_t decode_mode(input logic [2:0] code);
    dtm_mode_t m;
    m = DTM_ONE_SHOT;
    if (code == 3'h1) begin
      m = DTM_PERIODIC;
    end else if (code == 3'h2) begin
      m = DTM_CAP_COUNT;
    end else if (code == 3'h3) begin
      m = DTM_CAP_TIME;
    end else if (code == 3'h4) begin
      m = DTM_PWM;
    end
    return m;
  endfunction

  // ==========================================================
  // Registers
  logic [15:0] cfg;
  logic [2:0] ctrl;
  logic [DTM_IRQ_COUNT-1:0] irq_en;
  logic [DTM_IRQ_COUNT-1:0] irq_raw;
  logic [31:0] load_a;
  logic [31:0] load_b;
  logic [31:0] match_a;
  logic [31:0] match_b;
  logic [7:0] pre_a;
  logic [7:0] pre_b;
  logic ack;
  logic load_stb_a;
  logic load_stb_b;
  logic [31:0] rd_mux;
  logic [31:0] rtc_count;
  logic [15:0] rtc_div;
  logic rtc_prev;
  logic rtc_match;

  dtm_half_if hif_a ();
  dtm_half_if hif_b ();

  // ==========================================================
  // Bus decode
  wire logic req;
  wire logic wr_fire;
  wire logic [1:0] wide;
  wire logic joined;
  wire logic rtc_mode;
  wire logic hit_load_a;
  wire logic hit_load_b;
  wire logic hit_pre_both;
  wire logic [DTM_IRQ_COUNT-1:0] irq_masked;
  wire logic [DTM_IRQ_COUNT-1:0] irq_clear;
  wire logic [DTM_IRQ_COUNT-1:0] irq_set;
  wire logic rtc_edge;
  wire logic rtc_second;
  wire logic rtc_run;

  // One wait cycle, then the answer: writes land on the released edge
  assign req = read | write;
  assign waitrequest = req & ~ack;
  assign wr_fire = write & ack;
  assign wide = cfg[DTM_CFG_WIDE_LSB +: 2];
  assign joined = (wide != DTM_WIDE_PAIR);
  assign rtc_mode = (wide == DTM_WIDE_RTC);
  assign hit_load_a = wr_fire && (address == DTM_OFF_LOAD_A);
  assign hit_load_b = wr_fire && (address == DTM_OFF_LOAD_B);
  assign hit_pre_both = wr_fire && (address == DTM_OFF_PRE_BOTH);
  assign irq_clear = (wr_fire && (address == DTM_OFF_IRQ_CLEAR)) ?
                     writedata[DTM_IRQ_COUNT-1:0] : '0;
  assign irq_masked = irq_raw & irq_en;
  assign irq = |irq_masked; // R05

  // ==========================================================
  // Half control
  always_comb begin
    hif_a.enable = ctrl[DTM_CTRL_A_EN] & ~rtc_mode; // R01
    hif_a.joined = joined;
    hif_a.mode = joined ? ((wide == DTM_WIDE_PERIODIC) ? DTM_PERIODIC : DTM_ONE_SHOT) :
                 decode_mode(cfg[DTM_CFG_A_MODE_LSB +: 3]);
    hif_a.edge_sel = cfg[DTM_CFG_A_EDGE_LSB +: 2];
    hif_a.load = load_a;
    hif_a.match = match_a;
    hif_a.prescale = pre_a;
    hif_a.load_strobe = load_stb_a;
    // Half B stands idle while the halves are joined
    hif_b.enable = ctrl[DTM_CTRL_B_EN] & ~joined; // R01 R08
    hif_b.joined = 1'b0;
    hif_b.mode = decode_mode(cfg[DTM_CFG_B_MODE_LSB +: 3]);
    hif_b.edge_sel = cfg[DTM_CFG_B_EDGE_LSB +: 2];
    hif_b.load = load_b;
    hif_b.match = match_b;
    hif_b.prescale = pre_b;
    hif_b.load_strobe = load_stb_b;
  end

  dtm_half u_half_a (
    .mclk(mclk),
    .reset(reset),
    .cap_pin(cap_a_in),
    .hif(hif_a.half)
  );

  dtm_half u_half_b (
    .mclk(mclk),
    .reset(reset),
    .cap_pin(cap_b_in),
    .hif(hif_b.half)
  );

  assign pwm_a_out = hif_a.pwm;
  assign pwm_b_out = hif_b.pwm;

  // ==========================================================
  // RTC seconds counter
  assign rtc_edge = rtc_ref_in & ~rtc_prev;
  assign rtc_run = rtc_mode & ctrl[DTM_CTRL_RTC_EN];
  assign rtc_second = rtc_run && rtc_edge && (rtc_div == 16'(RTC_DIV - 1)); // R17

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rtc_prev <= 1'b0;
      rtc_div <= 16'h0000;
      rtc_count <= DTM_WORD_RST;
      rtc_match <= 1'b0;
    end else begin
      rtc_prev <= rtc_ref_in;
      rtc_match <= rtc_second && ((rtc_count + 32'h00000001) == match_a);
      if (!rtc_run || rtc_second) begin
        rtc_div <= 16'h0000;
      end else if (rtc_edge) begin
        rtc_div <= rtc_div + 16'h0001;
      end
      // Loading in RTC mode sets the seconds value directly
      if (rtc_mode && load_stb_a) begin
        rtc_count <= load_a; // R10
      end else if (rtc_second) begin
        rtc_count <= rtc_count + 32'h00000001; // R17
      end
    end
  end

  // ==========================================================
  // Interrupt status
  assign irq_set = {hif_b.cap_event, hif_b.cap_match, hif_b.timeout, rtc_match,
                    hif_a.cap_event, hif_a.cap_match, hif_a.timeout}; // R06

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_raw <= '0;
    end else begin
      // A new event wins over a clear in the same cycle
      irq_raw <= (irq_raw & ~irq_clear) | irq_set; // R03 R19
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    rd_mux = 32'h00000000;
    if (address == DTM_OFF_CFG) begin
      rd_mux = {16'h0000, cfg};
    end else if (address == DTM_OFF_CTRL) begin
      rd_mux = {29'h00000000, ctrl};
    end else if (address == DTM_OFF_IRQ_EN) begin
      rd_mux = {25'h0000000, irq_en};
    end else if (address == DTM_OFF_IRQ_RAW) begin
      rd_mux = {25'h0000000, irq_raw}; // R07
    end else if (address == DTM_OFF_IRQ_MASKED) begin
      rd_mux = {25'h0000000, irq_masked}; // R07
    end else if (address == DTM_OFF_LOAD_A) begin
      rd_mux = load_a; // R09
    end else if (address == DTM_OFF_LOAD_B) begin
      rd_mux = load_b; // R09
    end else if (address == DTM_OFF_MATCH_A) begin
      rd_mux = match_a;
    end else if (address == DTM_OFF_MATCH_B) begin
      rd_mux = match_b;
    end else if (address == DTM_OFF_PRE_A) begin
      rd_mux = {24'h000000, pre_a}; // R15
    end else if (address == DTM_OFF_PRE_B) begin
      rd_mux = {24'h000000, pre_b}; // R15
    end else if (address == DTM_OFF_VALUE_A) begin
      rd_mux = rtc_mode ? rtc_count : hif_a.value;
    end else if (address == DTM_OFF_VALUE_B) begin
      rd_mux = hif_b.value;
    end else if (address == DTM_OFF_CAPT_A) begin
      rd_mux = hif_a.capture;
    end else if (address == DTM_OFF_CAPT_B) begin
      rd_mux = hif_b.capture;
    end
  end

  // ==========================================================
  // Bus handshake and read data
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      if (read && !ack) begin
        readdata <= rd_mux;
      end
    end
  end

  // Load strobes trail the write by one edge so halves see the new value
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      load_stb_a <= 1'b0;
      load_stb_b <= 1'b0;
    end else begin
      load_stb_a <= hit_load_a;
      load_stb_b <= hit_load_b & ~joined; // R08
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg <= 16'h0000;
      ctrl <= 3'h0;
      irq_en <= '0;
      load_a <= DTM_WORD_RST;
      load_b <= DTM_WORD_RST;
      match_a <= DTM_WORD_RST;
      match_b <= DTM_WORD_RST;
      pre_a <= DTM_PRE_RST;
      pre_b <= DTM_PRE_RST;
    end else if (wr_fire) begin
      if (address == DTM_OFF_CFG) begin
        cfg <= writedata[15:0];
      end else if (address == DTM_OFF_CTRL) begin
        ctrl <= writedata[2:0]; // R01
      end else if (address == DTM_OFF_IRQ_EN) begin
        irq_en <= writedata[DTM_IRQ_COUNT-1:0]; // R05
      end else if (address == DTM_OFF_LOAD_A) begin
        load_a <= writedata;
      end else if (address == DTM_OFF_LOAD_B) begin
        load_b <= writedata;
      end else if (address == DTM_OFF_MATCH_A) begin
        match_a <= writedata; // R11
      end else if (address == DTM_OFF_MATCH_B) begin
        match_b <= writedata; // R11
      end else if (address == DTM_OFF_PRE_A) begin
        pre_a <= writedata[7:0]; // R13
      end else if (address == DTM_OFF_PRE_B) begin
        pre_b <= writedata[7:0]; // R13
      end else if (hit_pre_both) begin
        pre_a <= writedata[7:0]; // R13
        pre_b <= writedata[7:0];
      end
    end
  end

endmodule // dtm_top

// [dtm_pkg.sv]
// Shared constants and types for the dual load/match/prescale timer
package dtm_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] DTM_OFF_CFG = 8'h00;
  localparam logic [7:0] DTM_OFF_CTRL = 8'h04;
  localparam logic [7:0] DTM_OFF_IRQ_EN = 8'h08;
  localparam logic [7:0] DTM_OFF_IRQ_RAW = 8'h0C;
  localparam logic [7:0] DTM_OFF_IRQ_MASKED = 8'h10;
  localparam logic [7:0] DTM_OFF_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] DTM_OFF_LOAD_A = 8'h18;
  localparam logic [7:0] DTM_OFF_LOAD_B = 8'h1C;
  localparam logic [7:0] DTM_OFF_MATCH_A = 8'h20;
  localparam logic [7:0] DTM_OFF_MATCH_B = 8'h24;
  localparam logic [7:0] DTM_OFF_PRE_A = 8'h28;
  localparam logic [7:0] DTM_OFF_PRE_B = 8'h2C;
  localparam logic [7:0] DTM_OFF_VALUE_A = 8'h30;
  localparam logic [7:0] DTM_OFF_VALUE_B = 8'h34;
  localparam logic [7:0] DTM_OFF_CAPT_A = 8'h38;
  localparam logic [7:0] DTM_OFF_CAPT_B = 8'h3C;
  localparam logic [7:0] DTM_OFF_PRE_BOTH = 8'h40;

  // ==========================================================
  // Field positions
  localparam int DTM_CFG_WIDE_LSB = 0;
  localparam int DTM_CFG_A_MODE_LSB = 4;
  localparam int DTM_CFG_B_MODE_LSB = 8;
  localparam int DTM_CFG_A_EDGE_LSB = 12;
  localparam int DTM_CFG_B_EDGE_LSB = 14;
  localparam int DTM_CTRL_A_EN = 0;
  localparam int DTM_CTRL_B_EN = 1;
  localparam int DTM_CTRL_RTC_EN = 2;
  localparam int DTM_IRQ_A_TIMEOUT = 0;
  localparam int DTM_IRQ_A_CAP_MATCH = 1;
  localparam int DTM_IRQ_A_CAP_EVENT = 2;
  localparam int DTM_IRQ_RTC_MATCH = 3;
  localparam int DTM_IRQ_B_TIMEOUT = 4;
  localparam int DTM_IRQ_B_CAP_MATCH = 5;
  localparam int DTM_IRQ_B_CAP_EVENT = 6;
  localparam int DTM_IRQ_COUNT = 7;

  // ==========================================================
  // Field codes and reset values
  localparam logic [1:0] DTM_WIDE_PAIR = 2'h0;
  localparam logic [1:0] DTM_WIDE_ONE_SHOT = 2'h1;
  localparam logic [1:0] DTM_WIDE_PERIODIC = 2'h2;
  localparam logic [1:0] DTM_WIDE_RTC = 2'h3;
  localparam logic [1:0] DTM_EDGE_RISE = 2'h0;
  localparam logic [1:0] DTM_EDGE_FALL = 2'h1;
  localparam logic [31:0] DTM_WORD_RST = 32'h00000000;
  localparam logic [7:0] DTM_PRE_RST = 8'h00;
  localparam int DTM_RTC_DIV = 32768;

  typedef enum logic [2:0] {
    DTM_ONE_SHOT,
    DTM_PERIODIC,
    DTM_CAP_COUNT,
    DTM_CAP_TIME,
    DTM_PWM
  } dtm_mode_t;

endpackage

// [dtm_half_if.sv]
// Control and status bundle between the register file and one timer half
`timescale 1ns/1ns
interface dtm_half_if;
  logic enable;
  logic joined;
  dtm_pkg::dtm_mode_t mode;
  logic [1:0] edge_sel;
  logic [31:0] load;
  logic [31:0] match;
  logic [7:0] prescale;
  logic load_strobe;
  logic [31:0] value;
  logic [31:0] capture;
  logic timeout;
  logic cap_event;
  logic cap_match;
  logic pwm;

  modport ctl (
    output enable, joined, mode, edge_sel, load, match, prescale, load_strobe,
    input value, capture, timeout, cap_event, cap_match, pwm
  );
  modport half (
    input enable, joined, mode, edge_sel, load, match, prescale, load_strobe,
    output value, capture, timeout, cap_event, cap_match, pwm
  );
endinterface

// [dtm_half.sv]
// One timer half: prescaler, down counter, edge capture and pulse output
`timescale 1ns/1ns
module dtm_half
  import dtm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Capture pin, synchronous to mclk
  input wire logic cap_pin,
  // Register file side
  dtm_half_if.half hif
);

  // ==========================================================
  // Decode
  logic [7:0] pre_cnt;
  logic cap_prev;
  logic en_prev;
  logic [31:0] next_count;
  logic [31:0] next_capture;
  logic next_timeout;
  logic next_event;
  logic next_match;
  wire logic [31:0] load_eff;
  wire logic [31:0] match_eff;
  wire logic tick;
  wire logic rise;
  wire logic fall;
  wire logic edge_hit;
  wire logic start;
  wire logic at_zero;
  wire logic [31:0] count_dec;
  wire logic [31:0] next_down;

  // Split halves only ever see the low 16 bits
  assign load_eff = hif.joined ? hif.load : {16'h0000, hif.load[15:0]};
  assign match_eff = hif.joined ? hif.match : {16'h0000, hif.match[15:0]};
  assign tick = hif.joined | (pre_cnt == 8'h00); // R14
  assign rise = cap_pin & ~cap_prev;
  assign fall = ~cap_pin & cap_prev;
  assign edge_hit = (hif.edge_sel == DTM_EDGE_RISE) ? rise :
                    (hif.edge_sel == DTM_EDGE_FALL) ? fall : (rise | fall); // R18
  assign start = hif.enable & ~en_prev;
  assign at_zero = (hif.value == 32'h00000000);
  assign count_dec = hif.value - 32'h00000001;
  assign next_down = at_zero ? load_eff : count_dec;

  // ==========================================================
  // Counter behaviour
  always_comb begin
    next_count = hif.value;
    next_capture = hif.capture;
    next_timeout = 1'b0;
    next_event = 1'b0;
    next_match = 1'b0;
    if (start || (hif.enable && hif.load_strobe)) begin
      next_count = load_eff; // R10
    end else if (hif.enable) begin
      case (hif.mode)
        DTM_CAP_COUNT: begin
          if (edge_hit) begin
            next_count = next_down;
            next_match = (next_down == match_eff); // R11
          end
        end
        DTM_CAP_TIME: begin
          if (tick) begin
            next_count = next_down;
          end
          if (edge_hit) begin
            next_capture = hif.value; // R18
            next_event = 1'b1;
          end
        end
        default: begin
          if (tick && !at_zero) begin
            next_count = count_dec; // R20
            next_timeout = (hif.value == 32'h00000001);
          end else if (tick && hif.mode != DTM_ONE_SHOT) begin
            next_count = load_eff; // R16
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pre_cnt <= DTM_PRE_RST;
      cap_prev <= 1'b0;
      en_prev <= 1'b0;
    end else begin
      cap_prev <= cap_pin;
      en_prev <= hif.enable;
      if (!hif.enable || start || tick) begin
        pre_cnt <= hif.prescale; // R13
      end else begin
        pre_cnt <= pre_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hif.value <= DTM_WORD_RST;
      hif.capture <= DTM_WORD_RST;
      hif.timeout <= 1'b0;
      hif.cap_event <= 1'b0;
      hif.cap_match <= 1'b0;
      hif.pwm <= 1'b0;
    end else begin
      hif.value <= next_count;
      hif.capture <= next_capture;
      hif.timeout <= next_timeout;
      hif.cap_event <= next_event;
      hif.cap_match <= next_match;
      // Edge aligned: high from reload until the count falls to match
      hif.pwm <= hif.enable && (hif.mode == DTM_PWM) && (next_count > match_eff); // R12
    end
  end

endmodule // dtm_half

// [dtm_top_asserts.sv]
// Bus and interrupt checks for the dual timer top
`timescale 1ns/1ns
module dtm_top_asserts
  import dtm_pkg::*;
#(
  parameter int RTC_DIV = DTM_RTC_DIV
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Pins
  input wire logic cap_a_in,
  input wire logic cap_b_in,
  input wire logic pwm_a_out,
  input wire logic pwm_b_out,
  input wire logic rtc_ref_in,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Completed transfers
  wire rd_done = read && !waitrequest;
  wire wr_done = write && !waitrequest;
  // ==========================================================
  // Bus timing
  property p_wait_first;
    (read || write) && !$past(read || write) |-> waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("request not held off");
  property p_wait_one;
    waitrequest |=> !waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
  property p_idle;
    !(read || write) |-> !waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  // Readdata must not drift between reads, software may sample late
  property p_rd_hold;
    !read |=> $stable(readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata changed without read");
  // ==========================================================
  // Interrupts and fields
  property p_mask_off;
    wr_done && address == DTM_OFF_IRQ_EN && writedata[6:0] == 7'h00 |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
  property p_masked;
    rd_done && address == DTM_OFF_IRQ_MASKED |-> (readdata != 32'h0) == $past(irq);
  endproperty
  a_masked: assert property (p_masked) else $error("masked status disagrees");
  property p_sticky;
    $fell(irq) |-> $past(wr_done && (address == DTM_OFF_IRQ_CLEAR ||
      address == DTM_OFF_IRQ_EN));
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq dropped by itself");
  property p_sources;
    rd_done && (address == DTM_OFF_IRQ_RAW || address == DTM_OFF_IRQ_MASKED)
      |-> readdata[31:7] == 25'h0;
  endproperty
  a_sources: assert property (p_sources) else $error("status beyond seven bits");
  property p_prescale;
    rd_done && (address == DTM_OFF_PRE_A || address == DTM_OFF_PRE_B)
      |-> readdata[31:8] == 24'h0;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale wider than 8");
endmodule // dtm_top_asserts

bind dtm_top dtm_top_asserts #(.RTC_DIV(RTC_DIV)) u_dtm_chk (
  .mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .cap_a_in(cap_a_in), .cap_b_in(cap_b_in), .pwm_a_out(pwm_a_out),
  .pwm_b_out(pwm_b_out), .rtc_ref_in(rtc_ref_in), .irq(irq)
);

// [test_dtm_top.sv]
// Self-checking bench for the dual timer top
`timescale 1ns/1ns
module test_dtm_top
  import dtm_pkg::*;
;
  // Short seconds divider keeps the run brief
  localparam int RTC_N = 4;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic cap_a_in = 1'b0;
  logic cap_b_in = 1'b0;
  logic rtc_ref_in = 1'b0;
  logic [31:0] readdata, rv;
  logic waitrequest, pwm_a_out, pwm_b_out, irq;
  int err_count = 0;
  int checks_done = 0;

  dtm_top #(.RTC_DIV(RTC_N)) DUT (
    .mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .cap_a_in(cap_a_in), .cap_b_in(cap_b_in), .pwm_a_out(pwm_a_out),
    .pwm_b_out(pwm_b_out), .rtc_ref_in(rtc_ref_in), .irq(irq)
  );

  initial begin
    forever #50 mclk = ~mclk;
  end
  // ==========================================================
  // Reporting
  task automatic tally_and_finish();
    $display("checks_done %0d err_count %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ==========================================================
  // Bus master: request held until an edge samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        err_count++;
        tally_and_finish();
      end
      @(posedge mclk);
    end
    rv = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    check($sformatf("reg_%h", a), e, rv);
  endtask
  task automatic arm(input logic [31:0] cfg, la, ma, lb, ctl);
    wr(DTM_OFF_CTRL, 32'h00000000);
    wr(DTM_OFF_IRQ_CLEAR, 32'h0000007F);
    wr(DTM_OFF_CFG, cfg);
    wr(DTM_OFF_LOAD_A, la);
    wr(DTM_OFF_MATCH_A, ma);
    wr(DTM_OFF_LOAD_B, lb);
    wr(DTM_OFF_CTRL, ctl);
  endtask
  task automatic pulse(input int n, input logic rtc);
    repeat (n) begin
      {rtc_ref_in, cap_a_in} <= rtc ? 2'h2 : 2'h1;
      repeat (2) @(posedge mclk);
      {rtc_ref_in, cap_a_in} <= 2'h0;
      repeat (2) @(posedge mclk);
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    for (int i = 0; i < 16; i++) begin
      rd_chk(8'(i * 4), 32'h00000000);
    end
    wr(8'h44, 32'hFFFFFFFF);
    rd_chk(8'h44, 32'h00000000);
    wr(DTM_OFF_IRQ_RAW, 32'h0000007F);
    rd_chk(DTM_OFF_IRQ_RAW, 32'h00000000);
    wr(DTM_OFF_PRE_A, 32'h000000FF);
    rd_chk(DTM_OFF_PRE_A, 32'h000000FF);
    rd_chk(DTM_OFF_PRE_B, 32'h00000000);
    wr(DTM_OFF_PRE_BOTH, 32'h0000005A);
    rd_chk(DTM_OFF_PRE_A, 32'h0000005A);
    rd_chk(DTM_OFF_PRE_B, 32'h0000005A);
    wr(DTM_OFF_LOAD_B, 32'h0000BEEF);
    wr(DTM_OFF_MATCH_B, 32'h00001234);
    rd_chk(DTM_OFF_LOAD_B, 32'h0000BEEF);
    rd_chk(DTM_OFF_MATCH_B, 32'h00001234);
  endtask
  task automatic t_oneshot();
    wr(DTM_OFF_PRE_A, 32'h00000002);
    wr(DTM_OFF_IRQ_EN, 32'h00000001);
    arm(32'h00000000, 32'd8, 32'd0, 32'd0, 32'd1);
    repeat (12) @(posedge mclk);
    rd_chk(DTM_OFF_IRQ_RAW, 32'h00000000);
    repeat (20) @(posedge mclk);
    rd_chk(DTM_OFF_IRQ_RAW, 32'h00000001);
    rd_chk(DTM_OFF_VALUE_A, 32'h00000000);
    check("irq", 32'h1, {31'h0, irq});
    wr(DTM_OFF_IRQ_EN, 32'h00000000);
    check("irq", 32'h0, {31'h0, irq});
    rd_chk(DTM_OFF_IRQ_RAW, 32'h00000001);
    rd_chk(DTM_OFF_IRQ_MASKED, 32'h00000000);
    wr(DTM_OFF_IRQ_EN, 32'h0000007F);
    rd_chk(DTM_OFF_IRQ_MASKED, 32'h00000001);
    wr(DTM_OFF_IRQ_CLEAR, 32'h0000007E);
    check("irq", 32'h1, {31'h0, irq});
    wr(DTM_OFF_IRQ_CLEAR, 32'h00000001);
    check("irq", 32'h0, {31'h0, irq});
    rd_chk(DTM_OFF_IRQ_RAW, 32'h00000000);
  endtask
  task automatic t_periodic();
    wr(DTM_OFF_PRE_BOTH, 32'h00000000);
    for (int i = 1; i < 4; i++) begin
      arm(32'h00000110, 32'd3, 32'd0, 32'd5, 32'(i));
      repeat (30) @(posedge mclk);
      rd_chk(DTM_OFF_IRQ_RAW, 32'((i & 1) | ((i & 2) << 3)));
    end
    wr(DTM_OFF_IRQ_CLEAR, 32'h00000011);
    repeat (20) @(posedge mclk);
    rd_chk(DTM_OFF_IRQ_RAW, 32'h00000011);
  endtask
  task automatic t_reload();
    arm(32'h00000010, 32'd1000, 32'd0, 32'd0, 32'd1);
    repeat (10) @(posedge mclk);
    wr(DTM_OFF_LOAD_A, 32'd8);
    repeat (2) @(posedge mclk);
    bus(1'b0, DTM_OFF_VALUE_A, 32'h0);
    check("value_a_reloaded", 32'h1, {31'h0, rv <= 32'd8});
    rd_chk(DTM_OFF_LOAD_A, 32'd8);
  endtask
  task automatic t_capture();
    arm(32'h00000020, 32'd10, 32'd7, 32'd0, 32'd1);
    pulse(2, 1'b0);
    bus(1'b0, DTM_OFF_IRQ_RAW, 32'h0);
    check("cap_match_early", 32'h0, rv & 32'h2);
    pulse(1, 1'b0);
    bus(1'b0, DTM_OFF_IRQ_RAW, 32'h0);
    check("cap_match", 32'h2, rv & 32'h2);
    arm(32'h00001030, 32'h0000FFFF, 32'd0, 32'd0, 32'd1);
    cap_a_in <= 1'b1;
    repeat (4) @(posedge mclk);
    bus(1'b0, DTM_OFF_IRQ_RAW, 32'h0);
    check("event_on_rise", 32'h0, rv & 32'h4);
    cap_a_in <= 1'b0;
    repeat (4) @(posedge mclk);
    bus(1'b0, DTM_OFF_IRQ_RAW, 32'h0);
    check("event_on_fall", 32'h4, rv & 32'h4);
    bus(1'b0, DTM_OFF_CAPT_A, 32'h0);
    check("capt_a", 32'h1, {31'h0, rv != 0 && rv < 32'h10000});
  endtask
  task automatic t_pwm();
    int hi;
    int hb;
    int e;
    hi = 0;
    hb = 0;
    e = (9 - 3) * 100 / (9 + 1);
    wr(DTM_OFF_MATCH_B, 32'd5);
    arm(32'h00000440, 32'd9, 32'd3, 32'd9, 32'd3);
    repeat (20) @(posedge mclk);
    repeat (100) begin
      @(posedge mclk);
      hi += (pwm_a_out === 1'b1);
      hb += (pwm_b_out === 1'b1);
    end
    check("pwm_high", 32'h1, {31'h0, hi >= e - 2 && hi <= e + 2});
    check("pwm_b_high", 32'h1, {31'h0, hb >= 38 && hb <= 42});
  endtask
  task automatic t_rtc();
    arm(32'h00000003, 32'd0, 32'd2, 32'd0, 32'h00000004);
    wr(DTM_OFF_IRQ_EN, 32'h00000008);
    pulse(RTC_N, 1'b1);
    rd_chk(DTM_OFF_VALUE_A, 32'd1);
    rd_chk(DTM_OFF_IRQ_RAW, 32'h00000000);
    pulse(RTC_N, 1'b1);
    rd_chk(DTM_OFF_VALUE_A, 32'd2);
    rd_chk(DTM_OFF_IRQ_RAW, 32'h00000008);
    check("irq", 32'h1, {31'h0, irq});
  endtask
  task automatic t_joined();
    wr(DTM_OFF_PRE_A, 32'h000000FF);
    arm(32'h00000001, 32'h00012345, 32'd0, 32'd0, 32'd1);
    repeat (10) @(posedge mclk);
    bus(1'b0, DTM_OFF_VALUE_A, 32'h0);
    check("value_upper", 32'h00000001, rv >> 16);
    check("value_run", 32'h1, {31'h0, rv < 32'h00012345 && rv > 32'h00012300});
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_oneshot();
    t_periodic();
    t_reload();
    t_capture();
    t_pwm();
    t_rtc();
    t_joined();
    tally_and_finish();
  end
endmodule // test_dtm_top
